// [src/plw_regs.vh]
// register indices, field positions, reset values and counts of the loop guard
`ifndef PLW_REGS_VH
`define PLW_REGS_VH
`define PLW_IDX_MODE 16'hFF48
`define PLW_IDX_KICK 16'hFF49
`define PLW_IDX_CAUSE 16'hFF50
`define PLW_IDX_IRQ_STAT 16'hFF51
`define PLW_IDX_IRQ_MASK 16'hFF52
`define PLW_MODE_RST 8'h67
`define PLW_MODE_TOP 3'h3
`define PLW_MODE_STOP_BIT 4
`define PLW_MODE_SRC_BIT 3
`define PLW_KICK_KEY 8'hAC
`define PLW_KICK_READ 8'h9A
`define PLW_CAUSE_BIT 4
`define PLW_SLOW_BASE 5'h0B
`define PLW_SYS_BASE 5'h0D
`define PLW_RST_CYCLES 4'h8
`define PLW_IRQ_OVF 0
`define PLW_IRQ_KICK 1
`define PLW_IRQ_MODE 2
`define PLW_IRQ_W 3
`endif

// [src/plw_ahb_slave.v]
// ahb-lite slave front end: decodes word index, strobes reads and writes
`timescale 1ns/1ps
`default_nettype none
module plw_ahb_slave (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    output wire rd_stb,
    output wire [15:0] rd_idx,
    input wire [7:0] rd_data,
    output wire wr_stb,
    output reg [15:0] wr_idx,
    output wire [7:0] wr_data
);
    reg wr_pend_r;
    wire take;

    // address phase accepted on a valid transfer
    assign take = hsel & htrans[1] & hready & (hsize == 3'h2);
    assign rd_stb = take & ~hwrite;
    assign rd_idx = haddr[17:2];
    assign wr_stb = wr_pend_r;
    assign wr_data = hwdata[7:0];
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // capture write address, register read data for the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx <= 16'h0000;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend_r <= take & hwrite;
            if (take & hwrite) begin
                wr_idx <= haddr[17:2];
            end
            if (rd_stb) begin
                hrdata <= {24'h000000, rd_data};
            end
        end
    end
endmodule // plw_ahb_slave
`default_nettype wire

// [src/plw_tick_gate.v]
// count enable and oscillator run control of the loop guard
`timescale 1ns/1ps
`default_nettype none
module plw_tick_gate (
    input wire hresetn,
    input wire fixed_mode,
    input wire sel_stop,
    input wire sel_sys,
    input wire slow_osc_tick,
    input wire sysclk_stopped,
    input wire cpu_halt,
    input wire cpu_stop,
    input wire osc_stabilizing,
    input wire cpu_on_sysclk,
    input wire slow_osc_sw_off,
    output reg count_en,
    output wire slow_osc_run
);
    // oscillator forced on in fixed mode, off while reset is held or when switched off outside fixed mode
    assign slow_osc_run = hresetn & (fixed_mode | ~slow_osc_sw_off);

    // one enabled count per selected clock, gated per source
    always @* begin
        count_en = 1'b0;
        if (fixed_mode) begin
            count_en = slow_osc_tick;
        end else if (sel_stop) begin
            count_en = 1'b0;
        end else if (sel_sys) begin
            count_en = ~(sysclk_stopped | cpu_halt | cpu_stop | osc_stabilizing);
        end else begin
            count_en = slow_osc_tick & ~(cpu_halt | cpu_stop)
                & ~(cpu_on_sysclk & slow_osc_sw_off);
        end
    end
endmodule // plw_tick_gate
`default_nettype wire

// [src/plw_watchdog.v]
// program loop guard: mode and kick registers, counter, internal reset, irq
//
// Notes on behaviour
// - counter overflow without a kick forces an internal chip reset.
// - a guard-caused reset sets bit 4 of the reset cause register.
// - slow oscillator periods are 2^11 to 2^18 ticks.
// - system clock periods are 2^13 to 2^20 cycles, same order.
// - fixed option mode counts only the slow oscillator and never stops.
// - stoppable mode selects system clock, slow oscillator or stop; slow at reset.
// - counting starts right after reset at the longest slow period.
// - fixed mode accepts one period change after reset.
// - stoppable mode accepts one combined clock and period change only.
// - stoppable mode lets software stop the guard via clock select.
// - fixed mode keeps the slow oscillator running except in reset.
// - system clock source is gated when stopped, halted, stopped or stabilizing.
// - slow source gated in halt or stop, or when stopped from sysclk.
// - writing ACH to the kick register clears the counter and recounts.
// - other kick values reset the chip unless the first mode write stopped the guard; kick register reads 9AH.
// - second mode write resets, unless the first write stopped the guard.
// - mode resets to 67H; bits 4:3 pick clock, bits 2:0 period.
`timescale 1ns/1ps
`default_nettype none
`include "plw_regs.vh"
module plw_watchdog (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    input wire opt_osc_locked,
    input wire slow_osc_tick,
    input wire sysclk_stopped,
    input wire cpu_halt,
    input wire cpu_stop,
    input wire osc_stabilizing,
    input wire cpu_on_sysclk,
    input wire slow_osc_sw_off,
    output wire slow_osc_run,
    output wire chip_reset_req,
    output wire irq
);
    // reset image of the mode register, trimmed to its five writable bits
    localparam [7:0] mode_rst_byte = `PLW_MODE_RST;
    localparam [4:0] mode_rst_field = mode_rst_byte[4:0];

    // option strap, mode, counter and internal reset state
    reg strap_done_r;
    reg fixed_mode_r;
    reg [4:0] mode_r;
    reg [4:0] mode_nxt;
    reg mode_written_r;
    reg stopped_first_r;
    reg [20:0] cnt_r;
    reg [20:0] cnt_nxt;
    reg [3:0] rst_cnt_r;
    reg [3:0] rst_cnt_nxt;
    reg cause_r;
    reg [`PLW_IRQ_W-1:0] irq_stat_r;
    reg [`PLW_IRQ_W-1:0] irq_stat_nxt;
    reg [`PLW_IRQ_W-1:0] irq_mask_r;
    // decode strobes and read mux
    reg [7:0] rd_data;
    reg mode_fire;
    reg kick_fire;
    reg kick_ok;
    reg mode_load;

    // bus front end, gating and reset links
    wire rd_stb;
    wire [15:0] rd_idx;
    wire wr_stb;
    wire [15:0] wr_idx;
    wire [7:0] wr_data;
    wire count_en;
    wire ovf;
    wire in_reset;
    wire any_fire;
    wire [20:0] cnt_last;
    wire clr_cause;
    wire clr_stat;
    wire set_mask;

    ////////////////////////////////////////////////////////////////////////
    // last count value before overflow for a source and period field
    function [20:0] plw_last;
        input sys;
        input [2:0] per;
        reg [4:0] sh;
        begin
            sh = (sys ? `PLW_SYS_BASE : `PLW_SLOW_BASE) + {2'b00, per};
            plw_last = (21'h000001 << sh) - 21'h000001;
        end
    endfunction

    // strobe qualified by one register index
    function plw_hit;
        input stb;
        input [15:0] idx;
        input [15:0] want;
        begin
            plw_hit = stb && (idx == want);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus front end
    plw_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rd_stb(rd_stb),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .wr_stb(wr_stb),
        .wr_idx(wr_idx),
        .wr_data(wr_data)
    );

    // clock source gating
    plw_tick_gate u_gate (
        .hresetn(hresetn),
        .fixed_mode(fixed_mode_r),
        .sel_stop(mode_r[`PLW_MODE_STOP_BIT]),
        .sel_sys(mode_r[`PLW_MODE_SRC_BIT]),
        .slow_osc_tick(slow_osc_tick),
        .sysclk_stopped(sysclk_stopped),
        .cpu_halt(cpu_halt),
        .cpu_stop(cpu_stop),
        .osc_stabilizing(osc_stabilizing),
        .cpu_on_sysclk(cpu_on_sysclk),
        .slow_osc_sw_off(slow_osc_sw_off),
        .count_en(count_en),
        .slow_osc_run(slow_osc_run)
    );

    ////////////////////////////////////////////////////////////////////////
    // option strap caught on the first edge after reset release
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done_r <= 1'b0;
            fixed_mode_r <= 1'b1; // safe default until strap seen
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            fixed_mode_r <= opt_osc_locked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal reset window, overflow compare and register side effects
    assign in_reset = (rst_cnt_r != 4'h0);
    assign cnt_last = plw_last(mode_r[`PLW_MODE_SRC_BIT], mode_r[2:0]);
    assign ovf = count_en & (cnt_r == cnt_last);
    assign chip_reset_req = in_reset;
    assign clr_cause = plw_hit(rd_stb, rd_idx, `PLW_IDX_CAUSE);
    assign clr_stat = plw_hit(rd_stb, rd_idx, `PLW_IDX_IRQ_STAT);
    assign set_mask = plw_hit(wr_stb, wr_idx, `PLW_IDX_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // write decode: mode and kick effects
    always @* begin
        mode_fire = 1'b0;
        kick_fire = 1'b0;
        kick_ok = 1'b0;
        mode_load = 1'b0;
        mode_nxt = mode_r;
        if (wr_stb && !in_reset) begin
            if (wr_idx == `PLW_IDX_MODE) begin
                if (!mode_written_r) begin
                    mode_load = 1'b1;
                    if (fixed_mode_r) begin
                        mode_nxt = {2'b00, wr_data[2:0]};
                    end else begin
                        mode_nxt = wr_data[4:0];
                    end
                end else if (!stopped_first_r) begin
                    mode_fire = 1'b1;
                end
            end
            if (wr_idx == `PLW_IDX_KICK) begin
                if (wr_data == `PLW_KICK_KEY) begin
                    kick_ok = 1'b1;
                end else if (!stopped_first_r) begin
                    kick_fire = 1'b1;
                end
            end
        end
    end

    // any cause of an internal reset
    assign any_fire = ovf | mode_fire | kick_fire;

    ////////////////////////////////////////////////////////////////////////
    // counter: clears on kick or mode load, steps on enabled tick
    always @* begin
        cnt_nxt = cnt_r;
        if (in_reset || kick_ok || mode_load || ovf) begin
            cnt_nxt = 21'h000000;
        end else if (count_en) begin
            cnt_nxt = cnt_r + 21'h000001;
        end
    end

    // internal reset pulse length
    always @* begin
        rst_cnt_nxt = rst_cnt_r;
        if (any_fire && !in_reset) begin
            rst_cnt_nxt = `PLW_RST_CYCLES;
        end else if (in_reset) begin
            rst_cnt_nxt = rst_cnt_r - 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers; internal reset reinitialises mode and write-once state
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= mode_rst_field;
            mode_written_r <= 1'b0;
            stopped_first_r <= 1'b0;
            cnt_r <= 21'h000000;
            rst_cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            if (in_reset) begin
                mode_r <= mode_rst_field;
                mode_written_r <= 1'b0;
                stopped_first_r <= 1'b0;
            end else if (mode_load) begin
                mode_r <= mode_nxt;
                mode_written_r <= 1'b1;
                stopped_first_r <= ~fixed_mode_r & mode_nxt[`PLW_MODE_STOP_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset cause flag: set by guard reset, read clears, set wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_r <= 1'b0;
        end else if (any_fire && !in_reset) begin
            cause_r <= 1'b1;
        end else if (clr_cause) begin
            cause_r <= 1'b0;
        end
    end

    // sticky event bits, cleared by a status read unless set again
    always @* begin
        irq_stat_nxt = irq_stat_r;
        if (clr_stat) begin
            irq_stat_nxt = {`PLW_IRQ_W{1'b0}};
        end
        if (!in_reset) begin
            irq_stat_nxt[`PLW_IRQ_OVF] = irq_stat_nxt[`PLW_IRQ_OVF] | ovf;
            irq_stat_nxt[`PLW_IRQ_KICK] = irq_stat_nxt[`PLW_IRQ_KICK] | kick_fire;
            irq_stat_nxt[`PLW_IRQ_MODE] = irq_stat_nxt[`PLW_IRQ_MODE] | mode_fire;
        end
    end

    // event status and mask registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= {`PLW_IRQ_W{1'b0}};
            irq_mask_r <= {`PLW_IRQ_W{1'b0}};
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (set_mask) begin
                irq_mask_r <= wr_data[`PLW_IRQ_W-1:0];
            end
        end
    end

    // level interrupt while an unmasked event bit stands
    assign irq = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped indices read zero
    always @* begin
        rd_data = 8'h00;
        case (rd_idx)
            `PLW_IDX_MODE: rd_data = {`PLW_MODE_TOP, mode_r};
            `PLW_IDX_KICK: rd_data = `PLW_KICK_READ;
            `PLW_IDX_CAUSE: rd_data = {3'h0, cause_r, 4'h0};
            `PLW_IDX_IRQ_STAT: rd_data = {5'h00, irq_stat_r};
            `PLW_IDX_IRQ_MASK: rd_data = {5'h00, irq_mask_r};
            default: rd_data = 8'h00;
        endcase
    end
endmodule // plw_watchdog
`default_nettype wire

// [tb/plw_props.sv]
// port checker of the loop guard
`timescale 1ns/1ps
`default_nettype none
`include "plw_regs.vh"
module plw_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic opt_osc_locked,
    input wire logic slow_osc_sw_off,
    input wire logic slow_osc_run,
    input wire logic chip_reset_req
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // taken word transfers to the kick place and taken word reads of the mode place
    wire logic go = hsel && htrans[1] && hreadyout && hsize == 3'h2;
    wire logic at_kick = go && haddr[17:2] == `PLW_IDX_KICK;
    wire logic at_mode = go && !hwrite && haddr[17:2] == `PLW_IDX_MODE;
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_reset_pulse_len: assert property ($rose(chip_reset_req) |-> chip_reset_req [*8] ##1 !chip_reset_req)
        else $error("internal reset length wrong");
    a_kick_read_value: assert property (at_kick && !hwrite |=> hrdata == 32'h9A)
        else $error("kick read value wrong");
    a_mode_read_top: assert property (at_mode |=> hrdata[31:5] == 27'h3)
        else $error("mode read upper bits wrong");
    a_read_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_good_kick_quiet: assert property (at_kick && hwrite ##1 (hwdata[7:0] == 8'hAC && !chip_reset_req) |=> !chip_reset_req)
        else $error("good kick caused reset");
    a_fixed_osc_runs: assert property (opt_osc_locked |-> slow_osc_run)
        else $error("slow oscillator stopped in fixed mode");
    a_soft_osc_off: assert property ($past(hresetn) && !opt_osc_locked && slow_osc_sw_off |-> !slow_osc_run)
        else $error("slow oscillator runs though switched off");
endmodule // plw_props
bind plw_watchdog plw_props chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .opt_osc_locked(opt_osc_locked),
    .slow_osc_sw_off(slow_osc_sw_off), .slow_osc_run(slow_osc_run), .chip_reset_req(chip_reset_req));
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the loop guard
`timescale 1ns/1ps
`default_nettype none
`include "plw_regs.vh"
module testbench;
    logic hclk, hresetn, hsel, hwrite, opt, tick, r;
    logic [31:0] haddr, hwdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [5:0] g;
    wire logic hrdy, hresp, orun, crr, irq;
    wire logic [31:0] hrdata;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    logic [15:0] ri [6] = '{`PLW_IDX_MODE, `PLW_IDX_KICK, `PLW_IDX_CAUSE, `PLW_IDX_IRQ_STAT,
        `PLW_IDX_IRQ_MASK, 16'hFF60};
    logic [7:0] re [6] = '{8'h67, 8'h9A, 8'h00, 8'h00, 8'h00, 8'h00};
    plw_watchdog dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
        .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .opt_osc_locked(opt),
        .slow_osc_tick(tick), .sysclk_stopped(g[0]), .cpu_halt(g[1]), .cpu_stop(g[2]),
        .osc_stabilizing(g[3]), .cpu_on_sysclk(g[4]), .slow_osc_sw_off(g[5]),
        .slow_osc_run(orun), .chip_reset_req(crr), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            tally_and_finish;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // compare, bus, wait and gating helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {14'h0, idx, 2'h0};
        hwrite <= w;
        @(posedge hclk);
        while (hrdy !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hrdy !== 1'b1) @(posedge hclk);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic run_rst(input int lo, input int hi);
        n = 0;
        while (crr !== 1'b1 && n < 20000) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
        while (crr === 1'b1) @(posedge hclk);
    endtask
    task automatic gate(input logic [5:0] v, input int c);
        g <= v;
        repeat (c) @(posedge hclk);
    endtask
    task automatic rst(input logic fx);
        hresetn <= 1'b0;
        opt <= fx;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {hsel, hwrite, haddr, hwdata, htrans, g} = '0;
        hsize = 3'h2;
        tick = 1'b1;
        rst(1'b0);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ri[i], 8'h00);
            chk(q, {24'h0, re[i]});
        end
        $display("test reset values done");
        // system clock period 0, kick, then gated hold
        bus(1'b1, `PLW_IDX_IRQ_MASK, 8'h07);
        bus(1'b1, `PLW_IDX_MODE, 8'h68);
        repeat (4000) @(posedge hclk);
        bus(1'b1, `PLW_IDX_KICK, 8'hAC);
        gate(6'h01, 300);
        gate(6'h02, 400);
        gate(6'h08, 300);
        g <= 6'h00;
        run_rst(8190, 8194);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, `PLW_IDX_CAUSE, 8'h00);
        chk(q, 32'h10);
        bus(1'b0, `PLW_IDX_IRQ_STAT, 8'h00);
        chk(q, 32'h1);
        bus(1'b0, `PLW_IDX_IRQ_STAT, 8'h00);
        chk(q | {31'h0, irq}, 32'h0);
        $display("test system clock overflow done");
        // slow clock period 0 with stop gating
        bus(1'b1, `PLW_IDX_MODE, 8'h60);
        gate(6'h34, 500);
        chk({31'h0, orun}, 32'h0);
        g <= 6'h00;
        run_rst(2046, 2050);
        bus(1'b1, `PLW_IDX_KICK, 8'h55);
        run_rst(0, 3);
        bus(1'b0, `PLW_IDX_IRQ_STAT, 8'h00);
        chk(q, 32'h3);
        bus(1'b1, `PLW_IDX_MODE, 8'h67);
        bus(1'b1, `PLW_IDX_MODE, 8'h67);
        run_rst(0, 3);
        bus(1'b0, `PLW_IDX_IRQ_STAT, 8'h00);
        chk(q, 32'h4);
        $display("test faults done");
        // stopped guard ignores faults
        bus(1'b1, `PLW_IDX_MODE, 8'h70);
        bus(1'b1, `PLW_IDX_KICK, 8'h55);
        bus(1'b1, `PLW_IDX_MODE, 8'h68);
        r = 1'b0;
        repeat (3000) begin
            @(posedge hclk);
            r = r | crr;
        end
        chk({31'h0, r}, 32'h0);
        $display("test stopped guard done");
        // fixed option mode
        rst(1'b1);
        bus(1'b1, `PLW_IDX_MODE, 8'h78);
        bus(1'b0, `PLW_IDX_MODE, 8'h00);
        chk(q, 32'h60);
        g <= 6'h26;
        run_rst(2046, 2050);
        chk({31'h0, orun}, 32'h1);
        g <= 6'h00;
        bus(1'b1, `PLW_IDX_MODE, 8'h61);
        bus(1'b1, `PLW_IDX_MODE, 8'h61);
        run_rst(0, 3);
        $display("test fixed mode done");
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
